// file: hw/tcp_pkg.sv
package tcp_pkg;

  // Data width of the counter and compare registers
  localparam int CW = 16;
  localparam int SW = 4;

  // Register map, word offsets on the register port
  localparam logic [2:0] A_CTRL = 3'h0;
  localparam logic [2:0] A_FORCE = 3'h1;
  localparam logic [2:0] A_COUNT = 3'h2;
  localparam logic [2:0] A_CMPA = 3'h3;
  localparam logic [2:0] A_CMPB = 3'h4;
  localparam logic [2:0] A_CAPT = 3'h5;
  localparam logic [2:0] A_STAT = 3'h6;
  localparam logic [2:0] A_MASK = 3'h7;

  // Control register fields
  localparam int C_MODE = 0;
  localparam int C_RUN = 4;
  localparam int C_ACTA = 8;
  localparam int C_ACTB = 10;

  // Force register fields
  localparam int F_A = 0;
  localparam int F_B = 1;

  // Status and mask fields
  localparam int S_OVF = 0;
  localparam int S_CMPA = 1;
  localparam int S_CMPB = 2;
  localparam int S_CAP = 3;

  // Waveform mode select values
  localparam logic [3:0] M_NORMAL = 4'h0;
  localparam logic [3:0] M_CLRMATCH = 4'h4;
  localparam logic [3:0] M_PFC_CAP = 4'h8;
  localparam logic [3:0] M_PFC_CMPA = 4'h9;

  // Compare output action
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOG = 2'h1;
  localparam logic [1:0] ACT_CLR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // Reset values and counter limits
  localparam logic [CW-1:0] R_REG = 16'h0000;
  localparam logic [SW-1:0] R_FLAGS = 4'h0;
  localparam logic [CW-1:0] BOTTOM = 16'h0000;
  localparam logic [CW-1:0] MAXV = 16'hFFFF;
  localparam logic [CW-1:0] ONE = 16'h0001;

  // Count direction, Gray coded
  typedef enum logic [1:0] {
    ST_UP = 2'b00,
    ST_DOWN = 2'b01
  } tcp_dir_t;

endpackage

// file: hw/tcp_cmp_if.sv
`timescale 1ns/1ns
interface tcp_cmp_if;
  logic clk;
  logic rst_n;
  logic [15:0] cnt;
  logic tick;
  logic blk;
  logic pwm;
  logic load;
  logic up;
  modport ctl(output clk, rst_n, cnt, tick, blk, pwm, load, up);
  modport unit(input clk, rst_n, cnt, tick, blk, pwm, load, up);
endinterface

// file: hw/tcp_cmp_unit.sv
`timescale 1ns/1ns
module tcp_cmp_unit
  import tcp_pkg::*;
(
  // Shared counter view
  tcp_cmp_if.unit bus,
  // Software side
  input wire logic wr,
  input wire logic [CW-1:0] wdata,
  input wire logic [1:0] act,
  input wire logic frc,
  // Results
  output logic [CW-1:0] value,
  output logic [CW-1:0] active,
  output logic match,
  output logic pin
);

logic next_pin;

////////////////////////////////////////////////////////////////////////////////
// [RQ14] Equality only, so a value above TOP never matches while the count is at or below TOP
assign match = bus.tick & ~bus.blk & (bus.cnt == active);

always_comb begin
  next_pin = pin;
  if (bus.pwm) begin
    if (match) begin
      case (act)
        ACT_CLR: next_pin = ~bus.up;
        ACT_SET: next_pin = bus.up;
        ACT_TOG: next_pin = ~pin;
        default: next_pin = pin;
      endcase
    end
  // [RQ5] Forced match acts on the pin
  end else if (match | frc) begin
    case (act)
      ACT_CLR: next_pin = 1'b0;
      ACT_SET: next_pin = 1'b1;
      ACT_TOG: next_pin = ~pin;
      default: next_pin = pin;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// [RQ1] Software always lands in the buffer
always_ff @(posedge bus.clk or negedge bus.rst_n) begin
  if (!bus.rst_n) begin
    value <= R_REG;
    active <= R_REG;
    pin <= 1'b0;
  end else begin
    pin <= next_pin;
    if (wr) begin
      value <= wdata;
    end
    // [RQ3] Direct path outside PWM
    if (wr & ~bus.pwm) begin
      active <= wdata;
    // [RQ2] Buffer copied only at BOTTOM
    end else if (bus.load) begin
      active <= value;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
chk_direct_write: assert property (@(posedge bus.clk) disable iff (!bus.rst_n) // [RQ3]
  (wr && !bus.pwm) |=> (active == $past(wdata)))
  else $error("direct compare write lost");

chk_buffer_hold: assert property (@(posedge bus.clk) disable iff (!bus.rst_n) // [RQ1]
  (wr && bus.pwm && !bus.load) |=> (active == $past(active)))
  else $error("active compare changed by buffered write");

chk_update_bottom: assert property (@(posedge bus.clk) disable iff (!bus.rst_n) // [RQ2]
  ($past(bus.pwm) && $changed(active)) |-> $past(bus.load))
  else $error("active compare changed away from BOTTOM");

chk_force_set: assert property (@(posedge bus.clk) disable iff (!bus.rst_n) // [RQ4]
  (frc && !bus.pwm && act == ACT_SET) |=> pin)
  else $error("forced set did not raise pin");

endmodule

// file: hw/tcp_timer.sv
`timescale 1ns/1ns
// What this block does
// [RQ1] In PWM modes software reaches a buffer, not the active compare value.
// [RQ2] Buffered compare values move to active only at BOTTOM.
// [RQ3] In normal and clear-on-match modes compare writes act directly.
// [RQ4] Force bit fakes a compare match, non-PWM modes only.
// [RQ5] Forced match drives pin by output action, no flag, no counter reload.
// [RQ6] Counter write suppresses all compare matches in the next timer tick.
// [RQ7] Dual-slope resolution is log2(TOP+1), at most 16 bits.
// [RQ8] Dual-slope counts up to TOP then turns; TOP from mode 8 or 9.
// [RQ9] Counter holds TOP for exactly one tick before counting down.
// [RQ10] Each counter-compare equality sets that compare flag.
// [RQ11] Overflow flag rises in the same tick as the BOTTOM buffer load.
// [RQ12] Register defining TOP gets its flag set when TOP is reached.
// [RQ13] Software keeps TOP at or above every compare value in use.
// [RQ14] A compare value above TOP never matches.
// [RQ15] With capture register as TOP, compare A still drives its pin.
// [RQ16] After TOP, count down one per tick to BOTTOM, then up again.
module tcp_timer
  import tcp_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [CW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [CW-1:0] reg_rdata,
  // Compare pins
  output logic cmp_pin_a,
  output logic cmp_pin_b,
  // Interrupt
  output logic irq
);

////////////////////////////////////////////////////////////////////////////////
function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
  return a == off;
endfunction

function automatic logic [CW-1:0] step(input logic [CW-1:0] v, input logic up);
  return up ? v + ONE : v - ONE;
endfunction

////////////////////////////////////////////////////////////////////////////////
logic [CW-1:0] ctrl;
logic [CW-1:0] cnt;
logic [CW-1:0] next_cnt;
logic [CW-1:0] capt;
logic [SW-1:0] status;
logic [SW-1:0] mask;
logic [SW-1:0] ev;
logic [SW-1:0] clr;
logic blk;
tcp_dir_t dir;
tcp_dir_t next_dir;
logic [CW-1:0] rd_mux;
logic [CW-1:0] cmpa;
logic [CW-1:0] cmpa_act;
logic [CW-1:0] cmpb;
logic [CW-1:0] cmpb_act;
logic match_a;
logic match_b;

wire wr_en = reg_wr & clk_en;
wire wr_ctrl = wr_en & hit(reg_addr, A_CTRL);
wire wr_frc = wr_en & hit(reg_addr, A_FORCE);
wire wr_cnt = wr_en & hit(reg_addr, A_COUNT);
wire wr_cmpa = wr_en & hit(reg_addr, A_CMPA);
wire wr_cmpb = wr_en & hit(reg_addr, A_CMPB);
wire wr_capt = wr_en & hit(reg_addr, A_CAPT);
wire wr_stat = wr_en & hit(reg_addr, A_STAT);
wire wr_mask = wr_en & hit(reg_addr, A_MASK);

wire [3:0] mode = ctrl[C_MODE +: 4];
wire run = ctrl[C_RUN];
wire tick = clk_en & run;
wire pwm = (mode == M_PFC_CAP) | (mode == M_PFC_CMPA);

// [RQ8] TOP source by mode; [RQ15] compare A stays free in mode 8
wire [CW-1:0] top = (mode == M_PFC_CAP) ? capt :
  ((mode == M_PFC_CMPA) | (mode == M_CLRMATCH)) ? cmpa_act : MAXV;
wire at_bottom = (cnt == BOTTOM);
wire at_top = (cnt == top);

// [RQ4] Force honoured only outside PWM
wire frc_a = wr_frc & ~pwm & reg_wdata[F_A];
wire frc_b = wr_frc & ~pwm & reg_wdata[F_B];

////////////////////////////////////////////////////////////////////////////////
// Shared view for both compare channels
tcp_cmp_if cif();

assign cif.clk = mclk;
assign cif.rst_n = reset_n;
assign cif.cnt = cnt;
assign cif.tick = tick;
assign cif.blk = blk;
assign cif.pwm = pwm;
// [RQ2] Buffer load at BOTTOM of the dual slope
assign cif.load = tick & pwm & at_bottom;
assign cif.up = (dir == ST_UP);

tcp_cmp_unit u_cmp_a (
  .bus(cif.unit),
  .wr(wr_cmpa),
  .wdata(reg_wdata),
  .act(ctrl[C_ACTA +: 2]),
  .frc(frc_a),
  .value(cmpa),
  .active(cmpa_act),
  .match(match_a),
  .pin(cmp_pin_a)
);

tcp_cmp_unit u_cmp_b (
  .bus(cif.unit),
  .wr(wr_cmpb),
  .wdata(reg_wdata),
  .act(ctrl[C_ACTB +: 2]),
  .frc(frc_b),
  .value(cmpb),
  .active(cmpb_act),
  .match(match_b),
  .pin(cmp_pin_b)
);

////////////////////////////////////////////////////////////////////////////////
// Counter sequencing; a full-width counter gives 16-bit dual-slope range
always_comb begin
  next_cnt = cnt;
  next_dir = dir;
  if (tick) begin
    if (pwm) begin
      case (dir)
        ST_UP: begin
          // [RQ13] Turning on >= recovers if software drops TOP below count
          if (cnt >= top) begin
            // [RQ9] TOP seen for one tick, then turn
            next_dir = ST_DOWN;
            next_cnt = at_bottom ? BOTTOM : step(cnt, 1'b0);
          end else begin
            // [RQ8] Up slope; [RQ7] log2(TOP+1) bits of range
            next_cnt = step(cnt, 1'b1);
          end
        end
        ST_DOWN: begin
          // [RQ16] Down to BOTTOM, then up again
          if (at_bottom) begin
            next_dir = ST_UP;
            next_cnt = step(cnt, 1'b1);
          end else begin
            next_cnt = step(cnt, 1'b0);
          end
        end
        default: next_dir = ST_UP;
      endcase
    end else begin
      next_dir = ST_UP;
      if ((mode == M_CLRMATCH) & at_top) begin
        next_cnt = BOTTOM;
      end else begin
        next_cnt = step(cnt, 1'b1);
      end
    end
  end
  // Software write wins over counting
  if (wr_cnt) begin
    next_cnt = reg_wdata;
  end
end

always_ff @(posedge mclk or negedge reset_n) begin
  if (!reset_n) begin
    cnt <= R_REG;
    dir <= ST_UP;
  end else begin
    cnt <= next_cnt;
    dir <= next_dir;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Block flag lives until the next timer tick passes
always_ff @(posedge mclk or negedge reset_n) begin
  if (!reset_n) begin
    blk <= 1'b0;
  // [RQ6] Counter write blocks the following tick's matches
  end else if (wr_cnt) begin
    blk <= 1'b1;
  end else if (tick) begin
    blk <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Events; forced matches never reach the flags
// [RQ11] Overflow at BOTTOM, same tick as the buffer load
assign ev[S_OVF] = tick & (pwm ? at_bottom : (cnt == MAXV));
// [RQ10] Compare equality flags
assign ev[S_CMPA] = match_a;
assign ev[S_CMPB] = match_b;
// [RQ12] Capture flag when it defines TOP and TOP is reached
assign ev[S_CAP] = tick & (mode == M_PFC_CAP) & at_top;
assign clr = wr_stat ? reg_wdata[SW-1:0] : R_FLAGS;

// Set wins over a write-one clear in the same cycle
always_ff @(posedge mclk or negedge reset_n) begin
  if (!reset_n) begin
    status <= R_FLAGS;
  end else begin
    status <= (status & ~clr) | ev;
  end
end

assign irq = |(status & mask);

////////////////////////////////////////////////////////////////////////////////
// Software registers
always_ff @(posedge mclk or negedge reset_n) begin
  if (!reset_n) begin
    ctrl <= R_REG;
    capt <= R_REG;
    mask <= R_FLAGS;
  end else begin
    if (wr_ctrl) begin
      ctrl <= reg_wdata;
    end
    if (wr_capt) begin
      capt <= reg_wdata;
    end
    if (wr_mask) begin
      mask <= reg_wdata[SW-1:0];
    end
  end
end

always_comb begin
  case (reg_addr)
    A_CTRL: rd_mux = ctrl;
    A_COUNT: rd_mux = cnt;
    A_CMPA: rd_mux = cmpa;
    A_CMPB: rd_mux = cmpb;
    A_CAPT: rd_mux = capt;
    A_STAT: rd_mux = {12'h000, status};
    A_MASK: rd_mux = {12'h000, mask};
    default: rd_mux = R_REG;
  endcase
end

// Read data valid only in the cycle after the strobe
always_ff @(posedge mclk or negedge reset_n) begin
  if (!reset_n) begin
    reg_rdata <= R_REG;
  end else if (clk_en) begin
    reg_rdata <= reg_rd ? rd_mux : R_REG;
  end
end

////////////////////////////////////////////////////////////////////////////////
chk_write_block: assert property (@(posedge mclk) disable iff (!reset_n) // [RQ6]
  wr_cnt ##1 tick |-> (!match_a && !match_b))
  else $error("match not blocked after counter write");

chk_top_once: assert property (@(posedge mclk) disable iff (!reset_n) // [RQ9]
  (tick && pwm && dir == ST_UP && at_top && !at_bottom && !wr_cnt)
  |=> (cnt == $past(cnt) - ONE && dir == ST_DOWN))
  else $error("TOP not left after one tick");

chk_up_step: assert property (@(posedge mclk) disable iff (!reset_n) // [RQ8]
  (tick && pwm && dir == ST_UP && cnt < top && !wr_cnt)
  |=> (cnt == $past(cnt) + ONE))
  else $error("up slope step wrong");

chk_down_step: assert property (@(posedge mclk) disable iff (!reset_n) // [RQ16]
  (tick && pwm && dir == ST_DOWN && !at_bottom && !wr_cnt)
  |=> (cnt == $past(cnt) - ONE))
  else $error("down slope step wrong");

chk_ovf_load: assert property (@(posedge mclk) disable iff (!reset_n) // [RQ11]
  cif.load |=> status[S_OVF])
  else $error("overflow flag missing at BOTTOM load");

chk_capture_top: assert property (@(posedge mclk) disable iff (!reset_n) // [RQ12]
  (tick && mode == M_PFC_CAP && at_top) |=> status[S_CAP])
  else $error("capture flag missing at TOP");

chk_force_flagless: assert property (@(posedge mclk) disable iff (!reset_n) // [RQ5]
  (frc_a && !match_a && !status[S_CMPA]) |=> !status[S_CMPA])
  else $error("forced match raised flag");

chk_match_equal: assert property (@(posedge mclk) disable iff (!reset_n) // [RQ14]
  (tick && pwm && cmpb_act > top && cnt <= top) |-> !match_b)
  else $error("compare B matched above TOP");

chk_flag_match: assert property (@(posedge mclk) disable iff (!reset_n) // [RQ10]
  match_a |=> status[S_CMPA])
  else $error("compare A flag not set on match");

endmodule

// file: dv/tcp_timer_tb.sv
`timescale 1ns/1ns
module tcp_timer_tb
  import tcp_pkg::*;
();
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [CW-1:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [CW-1:0] reg_rdata;
  logic cmp_pin_a;
  logic cmp_pin_b;
  logic irq;
  logic rd_pend = 1'b0;
  logic [CW-1:0] exp_q[$];
  logic [31:0] seed = 32'h9A42;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  logic [1:0] acts[4] = '{ACT_SET, ACT_TOG, ACT_CLR, ACT_TOG};
  logic pexp[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic [3:0] md[2] = '{M_PFC_CAP, M_PFC_CMPA};
  int top[2] = '{6, 5};

  always #5 mclk = ~mclk;

  tcp_timer u_dut (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .cmp_pin_a(cmp_pin_a),
    .cmp_pin_b(cmp_pin_b),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function logic [CW-1:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  task check(input logic [CW-1:0] seen, input logic [CW-1:0] want);
    checks++;
    if (seen !== want) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, seen, want);
    end
  endtask

  task give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task bus(input logic w, input logic r, input logic [2:0] a, input logic [CW-1:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
  endtask

  task wr(input logic [2:0] a, input logic [CW-1:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  task rd(input logic [2:0] a, input logic [CW-1:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 16'h0000);
  endtask

  task idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask

  // Clears flags first, so the cycle of the next rise is exact
  task catch_irq(input logic [3:0] m, output int t);
    int k;
    wr(A_MASK, 16'(m));
    wr(A_STAT, 16'h000F);
    idle(0);
    for (k = 0; k < 100; k++) begin
      #1;
      if (irq === 1'b1) break;
      @(posedge mclk);
    end
    t = cyc;
    @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    rd_pend <= reg_rd;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      $display("[FAIL] %0t timeout", $time);
      give_verdict();
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(negedge mclk) begin
    if (rd_pend === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("[FAIL] %0t read with nothing expected", $time);
      end else begin
        check(reg_rdata, exp_q.pop_front());
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin : main
    logic [CW-1:0] r;
    int i;
    int t0;
    int t1;
    int t2;
    int t3;
    int hi;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    for (i = 0; i < 8; i++) rd(3'(i), R_REG);
    idle(1);
    check(16'({irq, cmp_pin_a, cmp_pin_b}), 16'h0000);
    r = rnd();
    wr(A_CAPT, r);
    rd(A_CAPT, r);
    clk_en <= 1'b0;
    wr(A_CAPT, ~r);
    clk_en <= 1'b1;
    rd(A_CAPT, r);
    wr(A_COUNT, r);
    wr(A_STAT, 16'h000F);
    for (i = 0; i < 4; i++) begin
      wr(A_CTRL, 16'(acts[i]) << C_ACTA | 16'(acts[i]) << C_ACTB);
      wr(A_FORCE, 16'h0003);
      idle(2);
      check(16'({cmp_pin_a, cmp_pin_b}), 16'({pexp[i], pexp[i]}));
    end
    wr(A_CTRL, 16'(M_PFC_CAP) | 16'(ACT_TOG) << C_ACTA);
    wr(A_FORCE, 16'h0003);
    idle(2);
    check(16'({cmp_pin_a, cmp_pin_b}), 16'h0003);
    rd(A_STAT, 16'h0000);
    rd(A_COUNT, r);
    wr(A_CTRL, 16'h0000);
    wr(A_COUNT, 16'h0000);
    wr(A_CMPA, 16'h0040);
    wr(A_CTRL, 16'h0010);
    for (i = 0; i < 2; i++) begin
      wr(A_STAT, 16'h000F);
      wr(A_COUNT, 16'h0040 - 16'(i));
      idle(4);
      rd(A_STAT, 16'(i) << S_CMPA);
    end
    wr(A_CTRL, 16'h0000);
    wr(A_COUNT, 16'h0000);
    wr(A_CMPA, 16'h0003);
    wr(A_CTRL, 16'(M_CLRMATCH) | 16'h0010);
    catch_irq(4'h2, t0);
    catch_irq(4'h2, t1);
    check(16'(t1 - t0), 16'h0004);
    for (i = 0; i < 2; i++) begin
      wr(A_CTRL, 16'h0000);
      wr(A_COUNT, 16'h0000);
      // TOP kept at or above compare A; B above TOP probes
      wr(A_CAPT, 16'h0006);
      wr(A_CMPA, (i == 1) ? 16'(top[i]) : 16'h0002);
      wr(A_CMPB, 16'h0009);
      wr(A_CTRL, 16'(md[i]) | 16'h0010 | 16'(ACT_CLR) << C_ACTA);
      catch_irq(4'h1, t0);
      catch_irq(4'h1, t1);
      catch_irq(4'h1, t2);
      catch_irq((i == 1) ? 4'h2 : 4'h8, t3);
      check(16'(t2 - t1), 16'(2 * top[i]));
      check(16'(t3 - t2), 16'(top[i]));
      if (i == 0) begin
        hi = 0;
        repeat (12) begin
          @(posedge mclk);
          #1;
          if (cmp_pin_a === 1'b1) hi++;
        end
        check(16'(hi), 16'h0004);
        @(posedge mclk);
        // buffered write, read back from buffer
        wr(A_CMPA, 16'h0003);
        rd(A_CMPA, 16'h0003);
      end
      wr(A_STAT, 16'h000F);
      idle(30);
      rd(A_STAT, (i == 1) ? 16'h0003 : 16'h000B);
      wr(A_MASK, 16'h0000);
      idle(1);
      check(16'(irq), 16'h0000);
      wr(A_MASK, 16'h0001);
      idle(1);
      check(16'(irq), 16'h0001);
    end
    idle(2);
    give_verdict();
  end
endmodule
